// *** inc/e1rc_params.svh ***
// Register offsets, field positions, reset values and codes of the E1 receive/diag config bank
`ifndef E1RC_PARAMS_SVH
`define E1RC_PARAMS_SVH
`define E1RC_ADDR_W 8
`define E1RC_DATA_W 8
`define E1RC_OFF_EQ_THR 8'h0b
`define E1RC_OFF_SLICER 8'h0c
`define E1RC_OFF_DIAG 8'h0d
`define E1RC_OFF_LOOP 8'h0e
`define E1RC_RST_EQ_THR 8'h15
`define E1RC_RST_SLICER 8'h18
`define E1RC_RST_DIAG 8'h00
`define E1RC_RST_LOOP 8'h00
`define E1RC_WMASK_EQ_THR 8'h5f
`define E1RC_WMASK_SLICER 8'h33
`define E1RC_WMASK_DIAG 8'h7f
`define E1RC_WMASK_LOOP 8'h07
`define E1RC_EQ_EN_BIT 6
`define E1RC_THR_HI 4
`define E1RC_THR_LO 0
`define E1RC_THR_MAX 5'h0a
`define E1RC_MARK_HI 5
`define E1RC_MARK_LO 4
`define E1RC_BOOST_HI 1
`define E1RC_BOOST_LO 0
`define E1RC_TW_HI 6
`define E1RC_TW_LO 5
`define E1RC_TWCLK_BIT 4
`define E1RC_INV_BIT 3
`define E1RC_CRIT_BIT 2
`define E1RC_FILL_BIT 1
`define E1RC_AUTO1_BIT 0
`define E1RC_RLP_BIT 2
`define E1RC_ALP_BIT 1
`define E1RC_DLP_BIT 0
`define E1RC_TW_NORMAL 2'h0
`define E1RC_TW_ONES 2'h1
`define E1RC_TW_PRBS 2'h2
`define E1RC_TW_RSVD 2'h3
`endif

// *** inc/e1rc_pkg.sv ***
// Types shared by the E1 receive/diag config bank
package e1rc_pkg;
  // Transmit stream source after pattern decode
  typedef enum logic [2:0]
  {
    e1rc_src_normal = 3'h0,
    e1rc_src_zeros = 3'h1,
    e1rc_src_ones = 3'h3,
    e1rc_src_prbs = 3'h2
  } e1rc_src_e;
  // Host register port request
  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } e1rc_req_s;
  // Receive front-end controls
  typedef struct packed
  {
    logic equalizer_enable;
    logic [4:0] signal_loss_threshold;
    logic [1:0] mark_threshold_sel;
    logic [1:0] monitor_boost_sel;
  } e1rc_rx_s;
  // Diagnostic and loopback controls
  typedef struct packed
  {
    e1rc_src_e tx_source;
    logic test_word_clock_sel;
    logic pseudo_random_invert;
    logic loss_criterion_sel;
    logic alarm_fill_active;
    logic remote_loop_enable;
    logic analog_loop_enable;
    logic digital_loop_enable;
  } e1rc_diag_s;
endpackage : e1rc_pkg

// *** verilog/e1rc_reg8.sv ***
// One host-writable 8-bit register with write mask and reset value
`timescale 1ns/1ps
module e1rc_reg8
#(
  parameter logic [7:0] RST = 8'h00,
  parameter logic [7:0] WMASK = 8'hff
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);
  // Masked bits keep their reset value forever
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= RST;
    end
    else if (we)
    begin
      q <= (wdata & WMASK) | (RST & ~WMASK);
    end
  end
endmodule : e1rc_reg8

// *** verilog/e1rc_cfg_regs.sv ***
// E1 receive equalizer, slicer, diagnostics and loopback configuration registers
//
// Overview of operation
// - Equalizer enable bit 6; threshold needs equalizer
// - Loss threshold defaults 10101; codes above 01010 reserved
// - Mark threshold bits 5-4 default 01
// - Monitor boost bits 1-0 select receive gain
// - Test word bits 6-5 choose inserted pattern
// - Code 00 passes data, or zeros
// - Bit 4 picks transmit or master pattern clock
// - Bit 3 inverts pseudo-random send and check
// - Bit 2 selects loss and alarm criterion
// - Alarm fill on receive rails during loss
// - Auto all-ones on loss when code 00
// - Bit 2 enables remote loopback
// - Bit 1 enables analog loopback
// - Bit 0 enables digital loopback
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "e1rc_params.svh"
module e1rc_cfg_regs
(
  input wire logic mclk,
  input wire logic reset_n,
  input e1rc_pkg::e1rc_req_s req,
  input wire logic signal_loss_pin,
  output logic [7:0] rdata,
  output e1rc_pkg::e1rc_rx_s rx_cfg,
  output e1rc_pkg::e1rc_diag_s diag_cfg,
  output logic threshold_reserved
);
  import e1rc_pkg::*;

  // Register contents
  logic [7:0] eq_thr_q;
  logic [7:0] slicer_q;
  logic [7:0] diag_q;
  logic [7:0] loop_q;
  // Write enables per register
  logic [3:0] we;
  // Synchroniser for the loss level from the line side
  logic loss_meta;
  logic loss_sync;
  // Next values of the outputs
  e1rc_rx_s next_rx_cfg;
  e1rc_diag_s next_diag_cfg;
  logic [7:0] next_rdata;

  // Address decode of write strobes
  always_comb
  begin
    we[0] = req.wr && (req.addr == `E1RC_OFF_EQ_THR);
    we[1] = req.wr && (req.addr == `E1RC_OFF_SLICER);
    we[2] = req.wr && (req.addr == `E1RC_OFF_DIAG);
    we[3] = req.wr && (req.addr == `E1RC_OFF_LOOP);
  end

  // Equalizer and threshold register
  e1rc_reg8 #(.RST(`E1RC_RST_EQ_THR), .WMASK(`E1RC_WMASK_EQ_THR)) u_eq_thr
  (
    .mclk(mclk),
    .reset_n(reset_n),
    .we(we[0]),
    .wdata(req.wdata),
    .q(eq_thr_q)
  );
  // Slicer and gain register
  e1rc_reg8 #(.RST(`E1RC_RST_SLICER), .WMASK(`E1RC_WMASK_SLICER)) u_slicer
  (
    .mclk(mclk),
    .reset_n(reset_n),
    .we(we[1]),
    .wdata(req.wdata),
    .q(slicer_q)
  );
  // Pattern and alarm register
  e1rc_reg8 #(.RST(`E1RC_RST_DIAG), .WMASK(`E1RC_WMASK_DIAG)) u_diag
  (
    .mclk(mclk),
    .reset_n(reset_n),
    .we(we[2]),
    .wdata(req.wdata),
    .q(diag_q)
  );
  // Loopback register
  e1rc_reg8 #(.RST(`E1RC_RST_LOOP), .WMASK(`E1RC_WMASK_LOOP)) u_loop
  (
    .mclk(mclk),
    .reset_n(reset_n),
    .we(we[3]),
    .wdata(req.wdata),
    .q(loop_q)
  );

  // Two-stage synchroniser on the loss pin
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      loss_meta <= 1'b0;
      loss_sync <= 1'b0;
    end
    else
    begin
      loss_meta <= signal_loss_pin;
      loss_sync <= loss_meta;
    end
  end

  // Read mux, unmapped reads give zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (req.rd)
    begin
      case (req.addr)
        `E1RC_OFF_EQ_THR: next_rdata = eq_thr_q;
        `E1RC_OFF_SLICER: next_rdata = slicer_q;
        `E1RC_OFF_DIAG: next_rdata = diag_q;
        `E1RC_OFF_LOOP: next_rdata = loop_q;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Receive controls decode
  always_comb
  begin
    next_rx_cfg.equalizer_enable = eq_thr_q[`E1RC_EQ_EN_BIT];
    next_rx_cfg.signal_loss_threshold = eq_thr_q[`E1RC_THR_HI:`E1RC_THR_LO];
    next_rx_cfg.mark_threshold_sel = slicer_q[`E1RC_MARK_HI:`E1RC_MARK_LO];
    next_rx_cfg.monitor_boost_sel = slicer_q[`E1RC_BOOST_HI:`E1RC_BOOST_LO];
  end

  // Diagnostic controls decode
  always_comb
  begin
    next_diag_cfg.test_word_clock_sel = diag_q[`E1RC_TWCLK_BIT];
    next_diag_cfg.pseudo_random_invert = diag_q[`E1RC_INV_BIT];
    next_diag_cfg.loss_criterion_sel = diag_q[`E1RC_CRIT_BIT];
    next_diag_cfg.alarm_fill_active = diag_q[`E1RC_FILL_BIT] && loss_sync;
    next_diag_cfg.remote_loop_enable = loop_q[`E1RC_RLP_BIT];
    next_diag_cfg.analog_loop_enable = loop_q[`E1RC_ALP_BIT];
    next_diag_cfg.digital_loop_enable = loop_q[`E1RC_DLP_BIT];
    case (diag_q[`E1RC_TW_HI:`E1RC_TW_LO])
      `E1RC_TW_NORMAL:
      begin
        // Auto ones beats zeros and normal data while loss stands
        if (diag_q[`E1RC_AUTO1_BIT] && loss_sync)
          next_diag_cfg.tx_source = e1rc_src_ones;
        else if (diag_q[`E1RC_TWCLK_BIT])
          next_diag_cfg.tx_source = e1rc_src_zeros;
        else
          next_diag_cfg.tx_source = e1rc_src_normal;
      end
      `E1RC_TW_ONES: next_diag_cfg.tx_source = e1rc_src_ones;
      `E1RC_TW_PRBS: next_diag_cfg.tx_source = e1rc_src_prbs;
      default: next_diag_cfg.tx_source = e1rc_src_normal; // Reserved code
    endcase
  end

  // Registered outputs
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata <= 8'h00;
      rx_cfg <= '0;
      diag_cfg <= '0;
      threshold_reserved <= 1'b0;
    end
    else
    begin
      rdata <= next_rdata;
      rx_cfg <= next_rx_cfg;
      diag_cfg <= next_diag_cfg;
      // Flags a reserved threshold code while the equalizer is on
      threshold_reserved <= eq_thr_q[`E1RC_EQ_EN_BIT]
        && (eq_thr_q[`E1RC_THR_HI:`E1RC_THR_LO] > `E1RC_THR_MAX);
    end
  end

  // Read data one cycle after strobe
  property p_read_slicer;
    @(posedge mclk) disable iff (!reset_n)
    (req.rd && req.addr == `E1RC_OFF_SLICER) |=> (rdata == $past(slicer_q));
  endproperty
  a_read_slicer: assert property (p_read_slicer) else $error("slicer read wrong");

  // Written diag value reaches the register
  property p_write_diag;
    @(posedge mclk) disable iff (!reset_n)
    we[2] |=> (diag_q == ($past(req.wdata) & `E1RC_WMASK_DIAG));
  endproperty
  a_write_diag: assert property (p_write_diag) else $error("diag write lost");

  // Reserved slicer bits hold default
  property p_slicer_rsvd;
    @(posedge mclk) disable iff (!reset_n)
    1'b1 |-> (slicer_q & ~`E1RC_WMASK_SLICER) == (`E1RC_RST_SLICER & ~`E1RC_WMASK_SLICER);
  endproperty
  a_slicer_rsvd: assert property (p_slicer_rsvd) else $error("reserved bits changed");

  // Equalizer output follows the written enable bit two cycles on
  property p_eq;
    @(posedge mclk) disable iff (!reset_n)
    we[0] |=> ##1 rx_cfg.equalizer_enable == $past(req.wdata[`E1RC_EQ_EN_BIT], 2);
  endproperty
  a_eq: assert property (p_eq) else $error("equalizer enable wrong");

  // Boost follows register two cycles after write
  sequence s_boost_write;
    we[1] ##1 1'b1;
  endsequence
  property p_boost;
    @(posedge mclk) disable iff (!reset_n)
    s_boost_write |=> rx_cfg.monitor_boost_sel
      == $past(req.wdata[`E1RC_BOOST_HI:`E1RC_BOOST_LO], 2);
  endproperty
  a_boost: assert property (p_boost) else $error("boost not applied");

  // All-ones pattern code drives ones
  property p_ones;
    @(posedge mclk) disable iff (!reset_n)
    (diag_q[`E1RC_TW_HI:`E1RC_TW_LO] == `E1RC_TW_ONES) |=> diag_cfg.tx_source == e1rc_src_ones;
  endproperty
  a_ones: assert property (p_ones) else $error("ones not inserted");

  // Zeros when code 00 and clock bit set without loss
  property p_zeros;
    @(posedge mclk) disable iff (!reset_n)
    (diag_q[`E1RC_TW_HI:`E1RC_TW_LO] == `E1RC_TW_NORMAL) && diag_q[`E1RC_TWCLK_BIT]
      && !loss_sync |=> diag_cfg.tx_source == e1rc_src_zeros;
  endproperty
  a_zeros: assert property (p_zeros) else $error("zeros not inserted");

  // Alarm fill only during loss
  property p_fill;
    @(posedge mclk) disable iff (!reset_n)
    diag_cfg.alarm_fill_active |-> $past(loss_sync) && $past(diag_q[`E1RC_FILL_BIT]);
  endproperty
  a_fill: assert property (p_fill) else $error("alarm fill without loss");

  // Auto ones during loss with code 00
  property p_auto;
    @(posedge mclk) disable iff (!reset_n)
    (diag_q[`E1RC_TW_HI:`E1RC_TW_LO] == `E1RC_TW_NORMAL) && diag_q[`E1RC_AUTO1_BIT]
      && loss_sync |=> diag_cfg.tx_source == e1rc_src_ones;
  endproperty
  a_auto: assert property (p_auto) else $error("auto ones missing");

  // Loopback outputs track register
  property p_loop;
    @(posedge mclk) disable iff (!reset_n)
    we[3] |=> ##1 {diag_cfg.remote_loop_enable, diag_cfg.analog_loop_enable,
      diag_cfg.digital_loop_enable} == $past(req.wdata[`E1RC_RLP_BIT:`E1RC_DLP_BIT], 2);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback wrong");

  // Loopback register read back one cycle after strobe
  property p_read_loop;
    @(posedge mclk) disable iff (!reset_n)
    (req.rd && req.addr == `E1RC_OFF_LOOP) |=> (rdata == $past(loop_q));
  endproperty
  a_read_loop: assert property (p_read_loop) else $error("loopback read wrong");

  // Read data bus idles at zero without a strobe
  property p_read_idle;
    @(posedge mclk) disable iff (!reset_n)
    !req.rd |=> (rdata == 8'h00);
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data not idle");

  // Equalizer write keeps reserved bits at default
  property p_write_eq_thr;
    @(posedge mclk) disable iff (!reset_n)
    we[0] |=> eq_thr_q == (($past(req.wdata) & `E1RC_WMASK_EQ_THR)
      | (`E1RC_RST_EQ_THR & ~`E1RC_WMASK_EQ_THR));
  endproperty
  a_write_eq_thr: assert property (p_write_eq_thr) else $error("threshold write lost");

  // No reserved-code flag while the equalizer is off
  property p_thr_off;
    @(posedge mclk) disable iff (!reset_n)
    !eq_thr_q[`E1RC_EQ_EN_BIT] |=> !threshold_reserved;
  endproperty
  a_thr_off: assert property (p_thr_off) else $error("flag with equalizer off");

  // Reserved threshold code flagged with equalizer on
  property p_thr_on;
    @(posedge mclk) disable iff (!reset_n)
    eq_thr_q[`E1RC_EQ_EN_BIT] && (eq_thr_q[`E1RC_THR_HI:`E1RC_THR_LO] > `E1RC_THR_MAX)
      |=> threshold_reserved;
  endproperty
  a_thr_on: assert property (p_thr_on) else $error("reserved code not flagged");

  // Pseudo-random code selects the sequence
  property p_prbs;
    @(posedge mclk) disable iff (!reset_n)
    (diag_q[`E1RC_TW_HI:`E1RC_TW_LO] == `E1RC_TW_PRBS) |=> diag_cfg.tx_source == e1rc_src_prbs;
  endproperty
  a_prbs: assert property (p_prbs) else $error("sequence not inserted");

  // Normal data with code 00, clock bit low and no auto ones
  property p_normal;
    @(posedge mclk) disable iff (!reset_n)
    (diag_q[`E1RC_TW_HI:`E1RC_TW_LO] == `E1RC_TW_NORMAL) && !diag_q[`E1RC_TWCLK_BIT]
      && !(diag_q[`E1RC_AUTO1_BIT] && loss_sync) |=> diag_cfg.tx_source == e1rc_src_normal;
  endproperty
  a_normal: assert property (p_normal) else $error("normal data blocked");

  // Alarm fill raised while loss stands and fill is enabled
  property p_fill_on;
    @(posedge mclk) disable iff (!reset_n)
    diag_q[`E1RC_FILL_BIT] && loss_sync |=> diag_cfg.alarm_fill_active;
  endproperty
  a_fill_on: assert property (p_fill_on) else $error("alarm fill missing");

  // Diag register write, then one cycle to reach the register
  sequence s_diag_write;
    we[2] ##1 1'b1;
  endsequence
  // Pattern clock select follows a written bit
  property p_twclk;
    @(posedge mclk) disable iff (!reset_n)
    s_diag_write |=> diag_cfg.test_word_clock_sel == $past(req.wdata[`E1RC_TWCLK_BIT], 2);
  endproperty
  a_twclk: assert property (p_twclk) else $error("pattern clock select wrong");
  // Sequence inversion follows a written bit
  property p_inv;
    @(posedge mclk) disable iff (!reset_n)
    s_diag_write |=> diag_cfg.pseudo_random_invert == $past(req.wdata[`E1RC_INV_BIT], 2);
  endproperty
  a_inv: assert property (p_inv) else $error("inversion wrong");
  // Loss criterion follows a written bit
  property p_crit;
    @(posedge mclk) disable iff (!reset_n)
    s_diag_write |=> diag_cfg.loss_criterion_sel == $past(req.wdata[`E1RC_CRIT_BIT], 2);
  endproperty
  a_crit: assert property (p_crit) else $error("criterion wrong");

  // Loopback register write, then one cycle to reach the register
  sequence s_loop_write;
    we[3] ##1 1'b1;
  endsequence
  // Remote loopback follows a written bit
  property p_remote;
    @(posedge mclk) disable iff (!reset_n)
    s_loop_write |=> diag_cfg.remote_loop_enable == $past(req.wdata[`E1RC_RLP_BIT], 2);
  endproperty
  a_remote: assert property (p_remote) else $error("remote loopback wrong");
  // Analog loopback follows a written bit
  property p_analog;
    @(posedge mclk) disable iff (!reset_n)
    s_loop_write |=> diag_cfg.analog_loop_enable == $past(req.wdata[`E1RC_ALP_BIT], 2);
  endproperty
  a_analog: assert property (p_analog) else $error("analog loopback wrong");
endmodule : e1rc_cfg_regs

// *** dv/e1_rx_and_diag_config_regs_test.sv ***
// Self-checking bench for the E1 receive and diagnostics config register bank
`timescale 1ns/1ps
`include "e1rc_params.svh"
`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch at %0t: %s", $time, m); end end
module e1_rx_and_diag_config_regs_test;
  import e1rc_pkg::*;
  logic mclk; // Register clock
  logic reset_n; // Async reset, active low
  e1rc_req_s req; // Host request
  logic signal_loss_pin; // Line loss level
  logic [7:0] rdata; // Read data
  e1rc_rx_s rx_cfg; // Receive controls
  e1rc_diag_s diag_cfg; // Diag controls
  logic threshold_reserved; // Reserved code flag
  int err_count; // Mismatches
  int tests_run; // Comparisons
  int cycles; // Timeout counter
  logic [7:0] rd_val; // Last read value
  // Expected source for {code, clock select}
  e1rc_src_e src_tab [8] = '{e1rc_src_normal, e1rc_src_zeros, e1rc_src_ones, e1rc_src_ones,
    e1rc_src_prbs, e1rc_src_prbs, e1rc_src_normal, e1rc_src_normal};
  logic [7:0] thr_tab [3] = '{8'h4a, 8'h4b, 8'h0b}; // Equalizer and threshold values
  logic [2:0] thr_exp = 3'b010; // Expected reserved flag per entry

  e1rc_cfg_regs dut (.mclk(mclk), .reset_n(reset_n), .req(req),
    .signal_loss_pin(signal_loss_pin), .rdata(rdata), .rx_cfg(rx_cfg),
    .diag_cfg(diag_cfg), .threshold_reserved(threshold_reserved));

  // Clock, 40 ns period
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count++;
      summarize();
    end
  end

  // Counts and verdict
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // One-cycle host write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask : wr

  // One-cycle host read, data taken in the following cycle
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 rd_val = rdata;
    `CHK(rd_val, e, "read data")
  endtask : rchk

  // Let a write reach the config outputs, or loss pass the synchroniser
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle

  initial
  begin
    req = '0;
    signal_loss_pin = 1'b0;
    reset_n = 1'b0;
    err_count = 0;
    tests_run = 0;
    cycles = 0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    // Reset values
    rchk(`E1RC_OFF_EQ_THR, 8'h15);
    rchk(`E1RC_OFF_SLICER, 8'h18);
    rchk(`E1RC_OFF_DIAG, 8'h00);
    rchk(`E1RC_OFF_LOOP, 8'h00);
    `CHK(rx_cfg, {1'b0, 5'h15, 2'h1, 2'h0}, "rx reset")
    `CHK(diag_cfg, 10'h000, "diag reset")
    `CHK(threshold_reserved, 1'b0, "flag reset")
    $display("test defaults done");
    // All ones, reserved bits keep defaults, unmapped reads zero
    wr(`E1RC_OFF_EQ_THR, 8'hff);
    wr(`E1RC_OFF_SLICER, 8'hff);
    wr(`E1RC_OFF_DIAG, 8'hff);
    wr(`E1RC_OFF_LOOP, 8'hff);
    wr(8'h10, 8'hff);
    rchk(`E1RC_OFF_EQ_THR, 8'h5f);
    rchk(`E1RC_OFF_SLICER, 8'h3b);
    rchk(`E1RC_OFF_DIAG, 8'h7f);
    rchk(`E1RC_OFF_LOOP, 8'h07);
    rchk(8'h10, 8'h00);
    `CHK(rx_cfg, {1'b1, 5'h1f, 2'h3, 2'h3}, "rx all ones")
    `CHK(threshold_reserved, 1'b1, "flag all ones")
    `CHK(diag_cfg, 10'h077, "diag all ones")
    $display("test readback done");
    // Mark threshold and monitor boost codes
    for (int i = 0; i < 4; i++)
    begin
      wr(`E1RC_OFF_SLICER, {2'h0, 2'(i), 2'h0, 2'(3 - i)});
      settle(2);
      `CHK(rx_cfg.mark_threshold_sel, 2'(i), "mark code")
      `CHK(rx_cfg.monitor_boost_sel, 2'(3 - i), "boost code")
    end
    // Threshold reserved codes and equalizer gating
    for (int i = 0; i < 3; i++)
    begin
      wr(`E1RC_OFF_EQ_THR, thr_tab[i]);
      settle(2);
      `CHK(threshold_reserved, thr_exp[i], "threshold flag")
      `CHK(rx_cfg.equalizer_enable, thr_tab[i][6], "equalizer")
    end
    $display("test receive fields done");
    // Test word codes against clock select
    for (int i = 0; i < 8; i++)
    begin
      wr(`E1RC_OFF_DIAG, {1'b0, 3'(i), 4'h0});
      settle(2);
      `CHK(diag_cfg.tx_source, src_tab[i], "pattern source")
      `CHK(diag_cfg.test_word_clock_sel, i[0], "clock select")
    end
    $display("test patterns done");
    // Loss-driven alarm fill and auto ones
    wr(`E1RC_OFF_DIAG, 8'h03);
    @(posedge mclk);
    signal_loss_pin <= 1'b1;
    settle(5);
    `CHK(diag_cfg.tx_source, e1rc_src_ones, "auto ones")
    `CHK(diag_cfg.alarm_fill_active, 1'b1, "fill on")
    wr(`E1RC_OFF_DIAG, 8'h41);
    settle(2);
    `CHK(diag_cfg.tx_source, e1rc_src_prbs, "auto ones off code")
    `CHK(diag_cfg.alarm_fill_active, 1'b0, "fill off")
    @(posedge mclk);
    signal_loss_pin <= 1'b0;
    wr(`E1RC_OFF_DIAG, 8'h03);
    settle(5);
    `CHK(diag_cfg.tx_source, e1rc_src_normal, "no loss")
    `CHK(diag_cfg.alarm_fill_active, 1'b0, "fill no loss")
    $display("test loss done");
    summarize();
  end
endmodule : e1_rx_and_diag_config_regs_test
